// ==== common/sarc_defines.svh ====
// Constants of the successive-approximation conversion sequencer.
`ifndef SARC_DEFINES_SVH
`define SARC_DEFINES_SVH

// ----------------------------------------------------------------------
// Resolution and code layout
// ----------------------------------------------------------------------
`define SARC_BITS 18
`define SARC_MSB 17
`define SARC_CNT_W 5
`define SARC_ONE_HOT_MSB 18'h20000
`define SARC_ALL_ONES 18'h3FFFF
`define SARC_ALL_ZERO 18'h00000
`define SARC_CODE_ZERO 18'h00000
`define SARC_CODE_POS_MAX 18'h1FFFF
`define SARC_CODE_NEG_MIN 18'h20000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SARC_CLK_HZ 25000000
`define SARC_SAMPLE_RATE_HZ 1330000
`define SARC_SAMPLE_CYCLES (`SARC_CLK_HZ / `SARC_SAMPLE_RATE_HZ)
`define SARC_DIV_W 8
`define SARC_STEP_DIV 8'h01
`define SARC_DIV_ZERO 8'h00
`define SARC_DIV_ONE 8'h01

`endif

// ==== common/sarc_pkg.sv ====
// Types shared by the conversion sequencer and its conversion clock.
`include "sarc_defines.svh"

package sarc_pkg;

	// ------------------------------------------------------------------
	// Sequencer phases
	// ------------------------------------------------------------------
	typedef enum logic [4:0] {
		SARC_ACQUIRE = 5'h01,
		SARC_OPEN_SW = 5'h02,
		SARC_GROUND = 5'h04,
		SARC_TRIAL = 5'h08,
		SARC_FINISH = 5'h10
	} sarc_phase_t;

	// ------------------------------------------------------------------
	// State records
	// ------------------------------------------------------------------
	typedef struct packed {
		sarc_phase_t phase;
		logic strobe_prev;
		logic chain_mode;
		logic busy;
		logic done;
		logic sw_closed;
		logic arr_on_input;
		logic [`SARC_MSB:0] sar;
		logic [`SARC_MSB:0] ptr;
		logic [`SARC_MSB:0] neg_arr;
		logic [`SARC_MSB:0] code;
	} sarc_seq_t;

	typedef struct packed {
		logic [`SARC_DIV_W-1:0] count;
		logic tick;
	} sarc_div_t;

endpackage : sarc_pkg

// ==== logic/sarc_conv_clock.sv ====
// Internal conversion clock: a restartable divider giving one-cycle ticks.
`timescale 1ns/1ns
`include "sarc_defines.svh"

module sarc_conv_clock #(
	parameter logic [`SARC_DIV_W-1:0] STEP_DIV = `SARC_STEP_DIV
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic restart,
	output logic tick
);

	sarc_pkg::sarc_div_t div_q;
	sarc_pkg::sarc_div_t div_d;

	// Restart aligns the first tick to the start of a conversion.
	always_comb begin
		div_d = div_q;
		div_d.tick = 1'b0;
		if (restart) begin
			div_d.count = `SARC_DIV_ZERO;
		end else if (div_q.count == STEP_DIV - `SARC_DIV_ONE) begin
			div_d.count = `SARC_DIV_ZERO;
			div_d.tick = 1'b1;
		end else begin
			div_d.count = div_q.count + `SARC_DIV_ONE;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	assign tick = div_q.tick;

endmodule : sarc_conv_clock

// ==== logic/sarc_sequencer.sv ====
// Successive-approximation conversion sequencer, top level.
`timescale 1ns/1ns
`include "sarc_defines.svh"

// How it works
// R01: Convert strobe rising edge ends acquisition, starts conversion.
// R02: Open ground switches first, then ground arrays.
// R03: Drive two matched 18-element binary-weighted arrays.
// R04: Resolve bits MSB first, halving weight each step.
// R05: Keep trial bit only if comparator agrees.
// R06: Return to acquisition, publish code and busy end.
// R07: Bit trials timed by internal conversion clock.
// R08: Code belongs to same sample, no latency.
// R09: Accept next conversion as soon as acquisition resumes.
// R10: Output is 18-bit two's complement code.
// R11: Positive overrange saturates to 0x1FFFF.
// R12: Negative full scale and underrange give 0x20000.
// R13: Strobe rising edge also latches interface mode.

module sarc_sequencer #(
	parameter logic [`SARC_DIV_W-1:0] STEP_DIV = `SARC_STEP_DIV
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic convert_strobe,
	input wire logic mode_select_in,
	input wire logic comparator_in,
	output logic pos_comparator_ground_switch,
	output logic neg_comparator_ground_switch,
	output logic arrays_on_input,
	output logic [`SARC_MSB:0] pos_array_to_ref,
	output logic [`SARC_MSB:0] neg_array_to_ref,
	output logic [`SARC_MSB:0] result_code,
	output logic conversion_done,
	output logic busy,
	output logic chain_mode
);

	// ------------------------------------------------------------------
	// State and reset value
	// ------------------------------------------------------------------
	localparam sarc_pkg::sarc_seq_t SEQ_RESET = '{
		phase: sarc_pkg::SARC_ACQUIRE,
		strobe_prev: 1'b0,
		chain_mode: 1'b0,
		busy: 1'b0,
		done: 1'b0,
		sw_closed: 1'b1,
		arr_on_input: 1'b1,
		sar: `SARC_ALL_ZERO,
		ptr: `SARC_ALL_ZERO,
		neg_arr: `SARC_ALL_ZERO,
		code: `SARC_CODE_ZERO
	};

	sarc_pkg::sarc_seq_t seq_q;
	sarc_pkg::sarc_seq_t seq_d;
	logic strobe_rise;
	logic start;
	logic tick;
	logic [`SARC_MSB:0] sar_dec;
	logic [`SARC_MSB:0] ptr_next;
	logic [`SARC_MSB:0] sar_trial;
	logic [`SARC_MSB:0] tried;
	logic [`SARC_MSB:0] neg_trial;
	logic last_bit;

	// ------------------------------------------------------------------
	// Start detection and conversion clock
	// ------------------------------------------------------------------
	assign strobe_rise = convert_strobe & ~seq_q.strobe_prev; // see R01
	// A new conversion is taken whenever acquisition is under way.
	assign start = strobe_rise & (seq_q.phase == sarc_pkg::SARC_ACQUIRE); // see R09

	// Only the divider paces the trials; no serial clock is involved.
	sarc_conv_clock #(
		.STEP_DIV(STEP_DIV)
	) u_conv_clock (
		.core_clk(core_clk),
		.reset(reset),
		.restart(start),
		.tick(tick)
	); // see R07

	// ------------------------------------------------------------------
	// Bit decision
	// ------------------------------------------------------------------
	assign last_bit = seq_q.ptr[0];
	// The trial bit stays only while the residue keeps its sign.
	assign sar_dec = comparator_in ? seq_q.sar : (seq_q.sar & ~seq_q.ptr); // see R05
	// The weight halves on each step, MSB first.
	assign ptr_next = last_bit ? seq_q.ptr : (seq_q.ptr >> 1); // see R04
	assign sar_trial = last_bit ? sar_dec : (sar_dec | ptr_next);

	// The negative array takes the complement of the trial code at and below the trial bit.
	genvar i;
	generate
		for (i = 0; i < `SARC_BITS; i++) begin : g_tried
			assign tried[i] = |ptr_next[`SARC_MSB:i]; // see R03
		end
	endgenerate
	assign neg_trial = ~sar_trial & tried; // see R03

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	always_comb begin
		seq_d = seq_q;
		seq_d.strobe_prev = convert_strobe;
		seq_d.done = 1'b0;
		case (seq_q.phase)
			sarc_pkg::SARC_ACQUIRE: begin
				if (start) begin
					seq_d.phase = sarc_pkg::SARC_OPEN_SW; // see R01
					seq_d.busy = 1'b1;
					seq_d.sw_closed = 1'b0; // see R02
					seq_d.chain_mode = ~mode_select_in; // see R13
				end
			end
			sarc_pkg::SARC_OPEN_SW: begin
				if (tick) begin
					seq_d.phase = sarc_pkg::SARC_GROUND;
					seq_d.arr_on_input = 1'b0; // see R02
				end
			end
			sarc_pkg::SARC_GROUND: begin
				if (tick) begin
					seq_d.phase = sarc_pkg::SARC_TRIAL;
					seq_d.sar = `SARC_ONE_HOT_MSB; // see R04
					seq_d.ptr = `SARC_ONE_HOT_MSB;
					seq_d.neg_arr = `SARC_ALL_ZERO;
				end
			end
			sarc_pkg::SARC_TRIAL: begin
				if (tick) begin
					seq_d.sar = sar_trial; // see R05
					seq_d.ptr = ptr_next;
					seq_d.neg_arr = neg_trial;
					if (last_bit) begin
						seq_d.phase = sarc_pkg::SARC_FINISH;
					end
				end
			end
			sarc_pkg::SARC_FINISH: begin
				// Inverting the offset-binary MSB gives two's complement;
				// all-ones and all-zero results are the saturated ends.
				seq_d.code = {~seq_q.sar[`SARC_MSB],
					seq_q.sar[`SARC_MSB-1:0]}; // see R10 see R11 see R12
				seq_d.phase = sarc_pkg::SARC_ACQUIRE; // see R06
				seq_d.busy = 1'b0; // see R06
				seq_d.done = 1'b1; // see R08
				seq_d.sw_closed = 1'b1;
				seq_d.arr_on_input = 1'b1;
				seq_d.sar = `SARC_ALL_ZERO;
				seq_d.ptr = `SARC_ALL_ZERO;
				seq_d.neg_arr = `SARC_ALL_ZERO;
			end
			default: begin
				seq_d = SEQ_RESET;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			seq_q <= SEQ_RESET;
		end else begin
			seq_q <= seq_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign pos_comparator_ground_switch = seq_q.sw_closed;
	assign neg_comparator_ground_switch = seq_q.sw_closed;
	assign arrays_on_input = seq_q.arr_on_input;
	assign pos_array_to_ref = seq_q.sar;
	assign neg_array_to_ref = seq_q.neg_arr;
	assign result_code = seq_q.code;
	assign conversion_done = seq_q.done;
	assign busy = seq_q.busy;
	assign chain_mode = seq_q.chain_mode;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	logic [`SARC_CNT_W-1:0] trial_cnt;

	// Counts the bit decisions of the conversion in progress.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			trial_cnt <= '0;
		end else if (seq_q.phase != sarc_pkg::SARC_TRIAL) begin
			trial_cnt <= '0;
		end else if (tick) begin
			trial_cnt <= trial_cnt + 1'b1;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	a_start_opens_sw: assert property ( // see R01
		start |=> busy && !pos_comparator_ground_switch
			&& !neg_comparator_ground_switch && arrays_on_input
	) else $error("conversion start did not open the ground switches");

	a_switch_before_gnd: assert property ( // see R02
		$fell(arrays_on_input) |-> $past(!pos_comparator_ground_switch)
			&& !neg_comparator_ground_switch
	) else $error("arrays left the inputs before switches opened");

	a_msb_first: assert property ( // see R04
		(seq_q.phase == sarc_pkg::SARC_GROUND) && tick
			|=> pos_array_to_ref == `SARC_ONE_HOT_MSB
			&& neg_array_to_ref == `SARC_ALL_ZERO
	) else $error("first trial is not the MSB alone");

	a_trial_count: assert property ( // see R04
		$rose(seq_q.phase == sarc_pkg::SARC_FINISH)
			|-> trial_cnt == `SARC_CNT_W'(`SARC_BITS)
	) else $error("conversion did not decide exactly all bits");

	a_drop_bit: assert property ( // see R05
		(seq_q.phase == sarc_pkg::SARC_TRIAL) && tick && !comparator_in
			|=> (pos_array_to_ref & $past(seq_q.ptr)) == `SARC_ALL_ZERO
	) else $error("rejected trial bit was kept");

	a_arrays_matched: assert property ( // see R03
		(seq_q.phase == sarc_pkg::SARC_TRIAL)
			|-> (pos_array_to_ref & neg_array_to_ref) == `SARC_ALL_ZERO
	) else $error("both arrays drive the same element to reference");

	a_done_end: assert property ( // see R06
		conversion_done |-> !busy && arrays_on_input
			&& pos_comparator_ground_switch && $past(busy)
	) else $error("done without return to acquisition");

	a_code_same: assert property ( // see R10
		conversion_done |-> result_code[`SARC_MSB-1:0]
			== $past(seq_q.sar[`SARC_MSB-1:0])
			&& result_code[`SARC_MSB] != $past(seq_q.sar[`SARC_MSB])
	) else $error("published code is not this sample");

	a_sat_pos: assert property ( // see R11
		conversion_done && $past(seq_q.sar) == `SARC_ALL_ONES
			|-> result_code == `SARC_CODE_POS_MAX
	) else $error("positive overrange did not saturate");

	a_sat_neg: assert property ( // see R12
		conversion_done && $past(seq_q.sar) == `SARC_ALL_ZERO
			|-> result_code == `SARC_CODE_NEG_MIN
	) else $error("negative underrange did not saturate");

	a_mode_latch: assert property ( // see R13
		start |=> chain_mode == !$past(mode_select_in)
	) else $error("interface mode not latched at conversion start");

	a_busy_ignore: assert property ( // see R09
		busy && strobe_rise && (seq_q.phase == sarc_pkg::SARC_TRIAL)
			|=> busy && (seq_q.phase != sarc_pkg::SARC_OPEN_SW)
			&& $stable(chain_mode)
	) else $error("strobe during conversion disturbed it");

	a_tick_paced: assert property ( // see R07
		(seq_q.phase == sarc_pkg::SARC_OPEN_SW) && !tick
			|=> seq_q.phase == sarc_pkg::SARC_OPEN_SW
	) else $error("conversion advanced without a conversion clock tick");

	c_conversion: cover property (start ##[1:300] conversion_done);
	c_sat_pos: cover property (conversion_done
		&& result_code == `SARC_CODE_POS_MAX);
	c_sat_neg: cover property (conversion_done
		&& result_code == `SARC_CODE_NEG_MIN);
	c_strobe_busy: cover property (busy && strobe_rise);
	c_chain_start: cover property (start && !mode_select_in);

endmodule : sarc_sequencer

// ==== test/sarc_analog_model.sv ====
// Comparator front end that stands in for the sampled analog input.
`timescale 1ns/1ns
`include "sarc_defines.svh"

module sarc_analog_model (
	input wire logic [`SARC_MSB:0] pos_array_to_ref,
	input wire logic signed [19:0] level,
	output logic comparator_in
);
	logic signed [19:0] clamped;
	logic [`SARC_MSB:0] target;

	// --------------------------------------------------------------
	// Residue sign
	// --------------------------------------------------------------
	// Out-of-range inputs pin the residue at the ends of the array.
	always_comb begin
		clamped = level;
		if (level > 20'sh1FFFF)
			clamped = 20'sh1FFFF;
		if (level < 20'shE0000)
			clamped = 20'shE0000;
		target = clamped[17:0] ^ 18'h20000;
		comparator_in = (pos_array_to_ref <= target);
	end
endmodule : sarc_analog_model

// ==== test/sarc_sequencer_test.sv ====
// Self-checking bench of the conversion sequencer.
`timescale 1ns/1ns
`include "sarc_defines.svh"

`define CHECK(got, exp) begin \
	n_tests++; \
	if ((got) !== (exp)) begin \
		n_errors++; \
		$display("mismatch at %0t: got %h expected %h", $time, got, exp); \
	end \
end

module sarc_sequencer_test;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic convert_strobe = 1'b0;
	logic mode_select_in = 1'b1;
	logic comparator_in;
	logic signed [19:0] level = 20'sh00000;
	logic pos_sw, neg_sw, arrays_on_input, conversion_done, busy, chain_mode;
	logic [`SARC_MSB:0] pos_arr, neg_arr, result_code;
	int n_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	localparam int LIMIT = 4000;

	sarc_sequencer #(.STEP_DIV(8'h01)) DUT (
		.core_clk(core_clk),
		.reset(reset),
		.convert_strobe(convert_strobe),
		.mode_select_in(mode_select_in),
		.comparator_in(comparator_in),
		.pos_comparator_ground_switch(pos_sw),
		.neg_comparator_ground_switch(neg_sw),
		.arrays_on_input(arrays_on_input),
		.pos_array_to_ref(pos_arr),
		.neg_array_to_ref(neg_arr),
		.result_code(result_code),
		.conversion_done(conversion_done),
		.busy(busy),
		.chain_mode(chain_mode)
	);

	sarc_analog_model MODEL (
		.pos_array_to_ref(pos_arr),
		.level(level),
		.comparator_in(comparator_in)
	);

	always #20 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_errors++;
			print_verdict();
		end
	end

	// --------------------------------------------------------------
	// Expected values
	// --------------------------------------------------------------
	function automatic logic [17:0] expect_code(input logic signed [19:0] v);
		if (v > 20'sh1FFFF)
			return 18'h1FFFF;
		if (v < 20'shE0000)
			return 18'h20000;
		return v[17:0];
	endfunction : expect_code

	task automatic print_verdict();
		$display("Comparisons: %0d, errors: %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict

	// --------------------------------------------------------------
	// One conversion
	// --------------------------------------------------------------
	// A poke drops and raises the strobe while busy; it must be ignored.
	task automatic convert(input logic signed [19:0] v, input logic mode,
			input logic poke);
		int n;
		int sw_at;
		int arr_at;
		logic bad;
		level = v;
		mode_select_in = mode;
		convert_strobe = 1'b1;
		n = 0;
		sw_at = 0;
		arr_at = 0;
		bad = 1'b0;
		do begin
			@(negedge core_clk);
			n++;
			if (pos_sw === 1'b0 && neg_sw === 1'b0 && sw_at == 0)
				sw_at = n;
			if (arrays_on_input === 1'b0 && arr_at == 0)
				arr_at = n;
			if ((pos_arr & neg_arr) !== 18'h00000)
				bad = 1'b1;
			if (n == 1)
				`CHECK(busy, 1'b1)
			if (n == 4)
				`CHECK(pos_arr, 18'h20000)
			if (n == 4)
				`CHECK(neg_arr, 18'h00000)
			if (poke && n == 8)
				convert_strobe = 1'b0;
			if (poke && n == 9)
				convert_strobe = 1'b1;
		end while (conversion_done !== 1'b1 && n < 40);
		`CHECK(n, 23)
		`CHECK(sw_at, 1)
		`CHECK(arr_at > sw_at, 1'b1)
		`CHECK(bad, 1'b0)
		`CHECK(result_code, expect_code(v))
		`CHECK({busy, pos_sw, arrays_on_input}, 3'h3)
		`CHECK(pos_arr, 18'h00000)
		`CHECK(chain_mode, ~mode)
		convert_strobe = 1'b0;
		@(negedge core_clk);
		`CHECK(conversion_done, 1'b0)
		`CHECK(result_code, expect_code(v))
		if (poke) begin
			repeat (25) begin
				@(negedge core_clk);
				if (conversion_done !== 1'b0 || busy !== 1'b0)
					bad = 1'b1;
			end
			`CHECK(bad, 1'b0)
		end
	endtask : convert

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		logic signed [19:0] corner [8];
		logic [31:0] rnd;
		logic signed [19:0] v;
		corner = '{20'sh00000, 20'sh00001, 20'shFFFFF, 20'sh1FFFF,
			20'sh20000, 20'shE0000, 20'shE0001, 20'shC0000};
		void'($urandom(99679));
		repeat (6) @(posedge core_clk);
		`CHECK({pos_sw, neg_sw, arrays_on_input, busy}, 4'hE)
		`CHECK(result_code, 18'h00000)
		@(negedge core_clk);
		reset = 1'b0;
		foreach (corner[i])
			convert(corner[i], i[0], i == 2);
		repeat (24) begin
			rnd = $urandom;
			v = {{2{rnd[17]}}, rnd[17:0]};
			if (rnd[31:29] == 3'h0)
				v = rnd[19:0];
			convert(v, rnd[28], rnd[27:25] == 3'h0);
		end
		print_verdict();
	end
endmodule : sarc_sequencer_test
